/* File: common/lmu_pkg.sv */
/*
 * Shared constants and types for the LED mode and user register bank.
 * Assumes an 8-bit register space reached over a plain strobe port.
 */
package lmu_pkg;

    // Register offsets
    localparam logic [7:0] LMU_ADDR_GCTL9   = 8'h0b;
    localparam logic [7:0] LMU_ADDR_RSVD_C  = 8'h0c;
    localparam logic [7:0] LMU_ADDR_USER1   = 8'h0d;
    localparam logic [7:0] LMU_ADDR_USER2   = 8'h0e;
    localparam logic [7:0] LMU_ADDR_USER3   = 8'h0f;

    // Field positions in global control 9
    localparam int LMU_BIT_TPID      = 0;
    localparam int LMU_BIT_LED_MODE  = 1;
    localparam int LMU_BIT_TEST_MODE = 4;
    localparam int LMU_BIT_PWR_SAVE  = 6;

    // Writable bits of global control 9 (bit 7 reads zero)
    localparam logic [7:0] LMU_GCTL9_WMASK = 8'h7f;
    // Reset value with the LED mode bit clear; strap fills it in later
    localparam logic [7:0] LMU_GCTL9_RESET = 8'h08;
    localparam logic [7:0] LMU_USER_RESET  = 8'h00;
    localparam logic [7:0] LMU_RSVD_VALUE  = 8'h00;
    localparam logic [7:0] LMU_UNMAPPED    = 8'h00;

    // Edges the strap chain needs before its last stage is valid
    localparam logic [1:0] LMU_STRAP_FILL  = 2'h3;

    // LED select codes, {high strap, mode bit}
    localparam logic [1:0] LMU_SEL_LA_FDX  = 2'h0;
    localparam logic [1:0] LMU_SEL_SPD_LA  = 2'h1;
    localparam logic [1:0] LMU_SEL_SPLIT   = 2'h2;

    // Per-port link state from the port logic
    typedef struct packed {
        logic link;    // Link up
        logic act;     // Activity
        logic fdx;     // Full duplex
        logic col;     // Collision
        logic spd100;  // 100 Mbps
    } lmu_port_stat_t;

    // Strap loader states
    typedef enum logic [2:0] {
        LMU_ST_FILL   = 3'b001,
        LMU_ST_SETTLE = 3'b010,
        LMU_ST_RUN    = 3'b100
    } lmu_state_t;

endpackage

/* File: design/lmu_led_map.sv */
/*
 * Combinational LED mapping for one port.
 * Assumes status inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module lmu_led_map
    import lmu_pkg::*;
(
    input  wire logic [1:0]     sel,   // {high strap, mode bit}
    input  wire lmu_port_stat_t stat,  // Port link state
    output logic      [3:0]     led    // Indicators 3..0, high = lit
);

    logic link_act;

    // Link/activity: lit on link, dark while traffic flows
    assign link_act = stat.link & ~stat.act;

    // Mapping per select code; unassigned outputs stay dark
    always_comb begin
        led = 4'h0;
        case (sel)
            LMU_SEL_LA_FDX: begin
                led[2] = link_act;
                led[1] = stat.fdx | stat.col;
                led[0] = stat.spd100;
            end
            LMU_SEL_SPD_LA: begin
                led[2] = link_act & stat.spd100;
                led[1] = link_act & ~stat.spd100;
                led[0] = stat.fdx;
            end
            LMU_SEL_SPLIT: begin
                led[3] = stat.act;
                led[2] = stat.link;
                led[1] = stat.fdx | stat.col;
                led[0] = stat.spd100;
            end
            default: led = 4'h0;
        endcase
    end

endmodule // lmu_led_map

/* File: design/lmu_regs.sv */
/*
 * Upper global register bank: control 9, reserved byte and three user
 * scratch bytes, plus per-port LED outputs selected by mode and strap.
 * Assumes one 250 MHz clock, straps stable around reset release, and a
 * master that issues single-cycle read or write strobes.
 */
// Chosen here: strobed register access.
`timescale 1ns/1ps
module lmu_regs
    import lmu_pkg::*;
#(
    parameter int NPORTS = 3                        // Ports with LEDs
)(
    input  wire logic                  clk,         // 250 MHz clock
    input  wire logic                  nrst,        // Async reset
    input  wire logic [7:0]            addr,        // Register address
    input  wire logic [7:0]            wr_data,     // Write data
    input  wire logic                  wr_en,       // Write strobe
    input  wire logic                  rd_en,       // Read strobe
    output logic      [7:0]            rd_data,     // Read data, next cycle
    input  wire logic                  led_select_low_strap,  // Strap pin
    input  wire logic                  led_select_high_strap, // Strap pin
    input  wire lmu_port_stat_t [NPORTS-1:0] port_stat, // Port state
    output logic      [NPORTS-1:0]     port_indicator_0,  // LED0 per port
    output logic      [NPORTS-1:0]     port_indicator_1,  // LED1 per port
    output logic      [NPORTS-1:0]     port_indicator_2,  // LED2 per port
    output logic      [NPORTS-1:0]     port_indicator_3,  // LED3 per port
    output logic                       test_mode,   // Test mode enable
    output logic                       phy_power_save, // PHY power save
    output logic                       special_tpid_mode, // Tag mode bit
    output logic                       strap_done   // Straps taken
);

    // Refuse port counts the per-port outputs cannot carry
    if (NPORTS < 1 || NPORTS > 8) begin : g_bad_nports
        $error("lmu_regs: NPORTS must be 1 to 8");
    end

    lmu_state_t  state;
    lmu_state_t  next_state;
    logic [1:0]  fill_cnt;
    logic [1:0]  next_fill_cnt;
    logic [2:0]  sync_low;
    logic [2:0]  sync_high;
    logic [2:0]  next_sync_low;
    logic [2:0]  next_sync_high;
    logic        sel_high;
    logic        next_sel_high;
    logic [7:0]  gctl9;
    logic [7:0]  next_gctl9;
    logic [7:0]  user1;
    logic [7:0]  next_user1;
    logic [7:0]  user2;
    logic [7:0]  next_user2;
    logic [7:0]  user3;
    logic [7:0]  next_user3;
    logic [7:0]  next_rd_data;
    logic        next_strap_done;
    logic [NPORTS-1:0] next_led0;
    logic [NPORTS-1:0] next_led1;
    logic [NPORTS-1:0] next_led2;
    logic [NPORTS-1:0] next_led3;
    logic        low_agree;
    logic        high_agree;

    // Shift each strap one stage further along its chain
    always_comb begin
        next_sync_low  = {sync_low[1:0], led_select_low_strap};
        next_sync_high = {sync_high[1:0], led_select_high_strap};
    end

    // Three-stage strap synchronisers; only stages 2 and 3 are looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_low  <= 3'h0;
            sync_high <= 3'h0;
        end else begin
            sync_low  <= next_sync_low;
            sync_high <= next_sync_high;
        end
    end

    // A strap still moving at release shows stages 2 and 3 apart; the
    // loader waits on these rather than trusting a fixed count
    assign low_agree  = (sync_low[1] == sync_low[2]);
    assign high_agree = (sync_high[1] == sync_high[2]);

    // Strap loader and register next values
    always_comb begin
        next_state      = state;
        next_fill_cnt   = fill_cnt;
        next_sel_high   = sel_high;
        next_gctl9      = gctl9;
        next_user1      = user1;
        next_user2      = user2;
        next_user3      = user3;
        next_strap_done = strap_done;
        case (state)
            LMU_ST_FILL: begin
                // Count the edges the chains need to fill after release
                next_fill_cnt = fill_cnt + 2'h1;
                if (fill_cnt == LMU_STRAP_FILL - 2'h1) begin
                    next_state = LMU_ST_SETTLE;
                end
            end
            LMU_ST_SETTLE: begin
                // Take the straps once both chains have settled
                if (low_agree && high_agree) begin
                    next_gctl9[LMU_BIT_LED_MODE] = sync_low[2];
                    next_sel_high   = sync_high[2];
                    next_strap_done = 1'b1;
                    next_state      = LMU_ST_RUN;
                end
            end
            LMU_ST_RUN: begin
                // Writes are taken only in RUN, earlier ones dropped, so none can race the strap load
                if (wr_en) begin
                    case (addr)
                        LMU_ADDR_GCTL9: begin
                            // Mode bit rewritable; test bit as given
                            next_gctl9 = wr_data & LMU_GCTL9_WMASK;
                        end
                        LMU_ADDR_USER1: next_user1 = wr_data;
                        LMU_ADDR_USER2: next_user2 = wr_data;
                        LMU_ADDR_USER3: next_user3 = wr_data;
                        default: ;  // Reserved byte ignores writes
                    endcase
                end
            end
            default: next_state = LMU_ST_FILL;
        endcase
    end

    // Register loader and control state; the mode bit resets clear and
    // the strap copy lands a few edges after release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= LMU_ST_FILL;
            fill_cnt   <= 2'h0;
            sel_high   <= 1'b0;
            gctl9      <= LMU_GCTL9_RESET;
            user1      <= LMU_USER_RESET;
            user2      <= LMU_USER_RESET;
            user3      <= LMU_USER_RESET;
            strap_done <= 1'b0;
        end else begin
            state      <= next_state;
            fill_cnt   <= next_fill_cnt;
            sel_high   <= next_sel_high;
            gctl9      <= next_gctl9;
            user1      <= next_user1;
            user2      <= next_user2;
            user3      <= next_user3;
            strap_done <= next_strap_done;
        end
    end

    // Read mux; data stands only in the cycle after the strobe
    // Reads are served from the first edge, even while straps load
    always_comb begin
        next_rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                LMU_ADDR_GCTL9:  next_rd_data = gctl9;
                LMU_ADDR_RSVD_C: next_rd_data = LMU_RSVD_VALUE;
                LMU_ADDR_USER1:  next_rd_data = user1;
                LMU_ADDR_USER2:  next_rd_data = user2;
                LMU_ADDR_USER3:  next_rd_data = user3;
                default:         next_rd_data = LMU_UNMAPPED;
            endcase
        end
    end

    // Per-port LED mapping, dark until the straps are taken
    // Gating on strap_done keeps a half-loaded select off the pins
    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_port
            logic [3:0] led;
            lmu_led_map u_map (
                .sel  ({sel_high, gctl9[LMU_BIT_LED_MODE]}),
                .stat (port_stat[p]),
                .led  (led)
            );
            assign next_led0[p] = strap_done & led[0];
            assign next_led1[p] = strap_done & led[1];
            assign next_led2[p] = strap_done & led[2];
            assign next_led3[p] = strap_done & led[3];
        end
    endgenerate

    // Output registers
    // Control outputs take the next value, so they move at the write edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data           <= 8'h00;
            port_indicator_0  <= '0;
            port_indicator_1  <= '0;
            port_indicator_2  <= '0;
            port_indicator_3  <= '0;
            test_mode         <= 1'b0;
            phy_power_save    <= 1'b0;
            special_tpid_mode <= 1'b0;
        end else begin
            rd_data           <= next_rd_data;
            port_indicator_0  <= next_led0;
            port_indicator_1  <= next_led1;
            port_indicator_2  <= next_led2;
            port_indicator_3  <= next_led3;
            test_mode         <= next_gctl9[LMU_BIT_TEST_MODE];
            phy_power_save    <= next_gctl9[LMU_BIT_PWR_SAVE];
            special_tpid_mode <= next_gctl9[LMU_BIT_TPID];
        end
    end

endmodule // lmu_regs

/* File: tb/lmu_regs_chk.sv */
/*
 * Port checker for the LED mode and user register bank.
 * Assumes one clock, async active-low reset and stable straps.
 */
`timescale 1ns/1ps
module lmu_regs_chk
    import lmu_pkg::*;
#(
    parameter int NPORTS = 3                   // Ports with LEDs
)(
    input wire logic                clk,       // Clock
    input wire logic                nrst,      // Async reset
    input wire logic [7:0]          addr,      // Address
    input wire logic [7:0]          wr_data,   // Write data
    input wire logic                wr_en,     // Write strobe
    input wire logic                rd_en,     // Read strobe
    input wire logic [7:0]          rd_data,   // Read data
    input wire logic                led_select_high_strap, // Strap
    input wire logic [NPORTS-1:0]   port_indicator_0, // LED0
    input wire logic [NPORTS-1:0]   port_indicator_3, // LED3
    input wire logic                test_mode, // Test mode
    input wire logic                strap_done // Straps taken
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic hi_q;
    wire logic gw = wr_en && addr == LMU_ADDR_GCTL9 && strap_done;
    wire logic tm_bit = wr_data[LMU_BIT_TEST_MODE];
    // Copy of the high select, taken while straps load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) hi_q <= 1'b0;
        else if (!strap_done) hi_q <= led_select_high_strap;
    end
    AST_RD_IDLE: assert property (!$past(rd_en)
        |-> rd_data == 8'h00)
        else $error("read data not zero outside read slot");
    AST_RSVD_RD: assert property (rd_en && addr == LMU_ADDR_RSVD_C
        |=> rd_data == LMU_RSVD_VALUE) else $error("reserved byte not zero");
    AST_UNMAP: assert property (rd_en && addr > LMU_ADDR_USER3
        |=> rd_data == LMU_UNMAPPED) else $error("unmapped read not zero");
    AST_DARK_PRE: assert property (!strap_done |->
        port_indicator_0 == '0 && port_indicator_3 == '0)
        else $error("LED lit before straps taken");
    AST_LED3_DARK: assert property (strap_done && !hi_q
        |=> port_indicator_3 == '0) else $error("LED3 lit in select 0x");
    AST_TEST_WR: assert property (gw
        |=> test_mode == $past(tm_bit))
        else $error("test mode bit not written");
    AST_TEST_HOLD: assert property (!gw |=> $stable(test_mode))
        else $error("test mode changed without write");
    AST_DONE_HOLD: assert property (strap_done |=> strap_done)
        else $error("strap done dropped");
    AST_DONE_SOON: assert property (!strap_done
        |-> ##[0:6] strap_done)
        else $error("straps not taken in time");
    // Main scenarios reached
    cover property (gw);
    cover property (rd_en && addr == LMU_ADDR_USER3);
    cover property (strap_done && hi_q && |port_indicator_3);
endmodule // lmu_regs_chk

bind lmu_regs lmu_regs_chk #(.NPORTS(NPORTS)) u_chk (.clk(clk), .nrst(nrst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .led_select_high_strap(led_select_high_strap),
    .port_indicator_0(port_indicator_0), .port_indicator_3(port_indicator_3),
    .test_mode(test_mode), .strap_done(strap_done));

/* File: tb/tb_lmu_regs.sv */
/*
 * Self-checking bench for the LED mode and user register bank.
 * Assumes the bench is the only bus master and drives the straps.
 */
`timescale 1ns/1ps
module tb_lmu_regs;
    import lmu_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, ud [13:15];
    logic lo_s = 1'b0, hi_s = 1'b0, tmode, done, psave, tpid;
    lmu_port_stat_t [2:0] port_stat = '0;
    logic [2:0] i0, i1, i2, i3;
    logic [14:0] r;
    logic [7:0] k;
    logic [3:0] g, e;
    integer seed = 7877, n_fail = 0, num_checks = 0, cyc = 0;
    // Clock at 250 MHz
    always #2 clk = ~clk;
    lmu_regs #(.NPORTS(3)) dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .led_select_low_strap(lo_s), .led_select_high_strap(hi_s),
        .port_stat(port_stat), .port_indicator_0(i0),
        .port_indicator_1(i1), .port_indicator_2(i2),
        .port_indicator_3(i3), .test_mode(tmode),
        .phy_power_save(psave), .special_tpid_mode(tpid), .strap_done(done));
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_led(input logic [3:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t led got %h exp %h", $time, got, exp);
        end
    endtask
    // Expected LEDs {3,2,1,0} for a select code and port state
    function automatic logic [3:0] exp_led(input logic [1:0] sel,
                                           input lmu_port_stat_t s);
        logic la;
        la = s.link & ~s.act;
        case (sel)
            2'h0: return {1'b0, la, s.fdx | s.col, s.spd100};
            2'h1: return {1'b0, la & s.spd100, la & ~s.spd100, s.fdx};
            2'h2: return {s.act, s.link, s.fdx | s.col, s.spd100};
            default: return 4'h0;
        endcase
    endfunction
    // Bus cycles: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk_reg(rd_data, exp);
    endtask
    // Reset with given straps, then wait for the straps to be taken
    task automatic do_reset(input logic lo, hi);
        @(posedge clk);
        nrst <= 1'b0; lo_s <= lo; hi_s <= hi;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk);
        @(posedge clk);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        for (int h = 0; h < 2; h++) begin
            do_reset(~h[0], h[0]);
            // Straps move once taken; mode and mapping must not follow
            lo_s <= h[0];
            hi_s <= ~h[0];
            k = LMU_GCTL9_RESET | {6'h00, ~h[0], 1'b0};
            rd(LMU_ADDR_GCTL9, k);
            for (int u = 13; u < 16; u++) rd(u[7:0], 8'h00);
            for (int m = 0; m < 2; m++) begin
                wr(LMU_ADDR_GCTL9, 8'h08 | (m[7:0] << 1));
                for (int n = 0; n < 20; n++) begin
                    r = 15'($random(seed));
                    @(posedge clk) port_stat <= r;
                    repeat (2) @(posedge clk);
                    @(negedge clk);
                    for (int p = 0; p < 3; p++) begin
                        e = exp_led({h[0], m[0]}, port_stat[p]);
                        g = {i3[p], i2[p], i1[p], i0[p]};
                        chk_led(g, e);
                    end
                end
            end
        end
        // Bits 6, 3 and 0 set, bit 7 dropped; test mode kept clear
        wr(LMU_ADDR_GCTL9, 8'hc9);
        @(negedge clk);
        chk_reg({5'h00, psave, tmode, tpid}, 8'h05);
        rd(LMU_ADDR_GCTL9, 8'h49);
        wr(LMU_ADDR_GCTL9, 8'h08);
        // Dropped write elsewhere; the reserved byte itself is left alone
        wr(8'h40, 8'hff);
        rd(LMU_ADDR_RSVD_C, LMU_RSVD_VALUE);
        rd(8'h40, LMU_UNMAPPED);
        // Random scratch traffic, with at least one idle cycle between strobes
        for (int u = 13; u < 16; u++) ud[u] = 8'h00;
        for (int n = 0; n < 40; n++) begin
            r = 15'($random(seed));
            k = 8'(r[2:1] % 3);
            if (r[0]) begin
                ud[13 + k] = r[10:3];
                wr(LMU_ADDR_USER1 + k, r[10:3]);
            end else begin
                rd(LMU_ADDR_USER1 + k, ud[13 + k]);
            end
        end
        report_and_stop();
    end
endmodule // tb_lmu_regs
